// ---- verilog/gpt_timer_unit.sv ----
/*
 * Dual 16-bit timer unit: 32-bit one-shot/periodic, 32-bit clock,
 * 16-bit one-shot/periodic with prescaler and 16-bit edge count.
 * Assumes one AHB-Lite master, asynchronous pins and a debug halt
 * level on the system clock.
 */
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module gpt_timer_unit #(
    parameter int unsigned RTC_DIV = gpt_pkg::RTC_DIV
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic ccp_even_in,
    input wire logic ccp_odd_in,
    input wire logic debug_halt_in,
    output logic irq_out,
    output logic adc_trig_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Bus slave
    logic wr_pend_r, rd_pend_r, hready_r, hresp_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r, rd_data;
    // Software registers
    logic [2:0] cfg_r;
    logic [2:0] mr_r [2];
    logic [15:0] ctl_r, imr_r, ris_r;
    logic [15:0] ilr_r [2];
    logic [15:0] mat_r [2];
    // Counters and prescalers
    logic [15:0] cnt_r [2];
    logic [15:0] cnt_nxt [2];
    logic [15:0] cnt_dec [2];
    logic [7:0] psr_r [2];
    logic [7:0] pre_r [2];
    logic [7:0] pre_nxt [2];
    // Divider, pins and decode
    logic [15:0] div_r;
    logic rtc_done_r, irq_r, trig_r, trig_nxt;
    logic [1:0] s1_r, s2_r, s3_r, rise, fall, hit, en, stall, ote, run, en_clr;
    logic [15:0] ev_set, en_mask, icr_clr;
    logic [31:0] c32, l32, mt32, c32_nxt;
    logic m32, mrtc, m16, wide, tick, rtc_first, addr_ok;

    // Edge select decode
    function automatic logic edge_hit(input logic [1:0] ev, input logic r, input logic f);
        return (ev == gpt_pkg::EVT_RISE && r) || (ev == gpt_pkg::EVT_FALL && f)
            || (ev == gpt_pkg::EVT_BOTH && (r || f));
    endfunction : edge_hit

    // Write strobe for one offset
    function automatic logic wr_at(input logic [7:0] off);
        return wr_pend_r && (addr_r == off);
    endfunction : wr_at

    // Mode field picks a down-counter
    function automatic logic is_timer(input logic [2:0] mr);
        return mr[1:0] == gpt_pkg::MODE_ONESHOT || mr[1:0] == gpt_pkg::MODE_PERIODIC;
    endfunction : is_timer

    // ------------------------------------------------------------
    // Bus slave: writes zero wait, reads one wait state
    // ------------------------------------------------------------
    assign addr_ok = hsel_in && htrans_in[1] && hready_in;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_ok && hwrite_in;
            rd_pend_r <= addr_ok && !hwrite_in;
            hready_r <= !(addr_ok && !hwrite_in);
            if (addr_ok) begin
                addr_r <= haddr_in[7:0];
            end
            if (rd_pend_r) begin
                hrdata_r <= rd_data;
            end
        end
    end
    // Registered bus outputs
    assign hrdata_out = hrdata_r;
    assign hreadyout_out = hready_r;
    assign hresp_out = hresp_r;

    // ------------------------------------------------------------
    // Mode and control decode
    // ------------------------------------------------------------
    assign m32 = cfg_r == gpt_pkg::CFG_32;
    assign mrtc = cfg_r == gpt_pkg::CFG_RTC;
    assign m16 = cfg_r == gpt_pkg::CFG_16;
    assign wide = m32 || mrtc;
    assign c32 = {cnt_r[1], cnt_r[0]};
    assign l32 = {ilr_r[1], ilr_r[0]};
    assign mt32 = {mat_r[1], mat_r[0]};
    // Decrement of each half
    assign cnt_dec[0] = cnt_r[0] - 16'h0001;
    assign cnt_dec[1] = cnt_r[1] - 16'h0001;

    // Control bits, A low byte, B high byte
    assign en = {ctl_r[gpt_pkg::B_SHIFT+gpt_pkg::CTL_EN], ctl_r[gpt_pkg::CTL_EN]};
    assign stall = {ctl_r[gpt_pkg::B_SHIFT+gpt_pkg::CTL_STALL], ctl_r[gpt_pkg::CTL_STALL]};
    assign ote = {ctl_r[gpt_pkg::B_SHIFT+gpt_pkg::CTL_OTE], ctl_r[gpt_pkg::CTL_OTE]};
    // Debug freeze, overridden by clock run bit in clock mode
    assign run = en & ~(stall & {2{debug_halt_in && !(mrtc && ctl_r[gpt_pkg::CTL_CLOCK_RUN_ENABLE])}});

    // Edge detect on synchronised pins
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
    assign hit[0] = edge_hit(ctl_r[gpt_pkg::CTL_EVT+:2], rise[0], fall[0]);
    assign hit[1] = edge_hit(ctl_r[gpt_pkg::B_SHIFT+gpt_pkg::CTL_EVT+:2], rise[1], fall[1]);

    // Slow tick and first clock selection
    assign tick = mrtc && rise[0] && (div_r == 16'(RTC_DIV - 1));
    assign rtc_first = wr_at(gpt_pkg::OFF_CFG) && hwdata_in[2:0] == gpt_pkg::CFG_RTC
        && !rtc_done_r;

    // Hardware enable clears, software flag clears
    assign en_mask = (16'(en_clr[0]) << gpt_pkg::CTL_EN)
        | (16'(en_clr[1]) << (gpt_pkg::B_SHIFT + gpt_pkg::CTL_EN));
    assign icr_clr = wr_at(gpt_pkg::OFF_ICR) ? hwdata_in[15:0] : 16'h0000;

    // ------------------------------------------------------------
    // Input synchroniser and clock divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
        end else begin
            s1_r <= {ccp_odd_in, ccp_even_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Divides pin edges down to a one-second tick
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !mrtc) begin
            div_r <= 16'h0000;
        end else if (rise[0]) begin
            div_r <= tick ? 16'h0000 : div_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Counter next state
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        en_clr = 2'h0;
        ev_set = 16'h0000;
        trig_nxt = 1'b0;
        c32_nxt = c32;
        if (wide) begin
            // Only timer A mode field matters here
            if (m32 && run[0]) begin
                if (c32 == 32'h0000_0000) begin
                    c32_nxt = l32;
                    ev_set[gpt_pkg::ST_TO] = 1'b1;
                    trig_nxt = ote[0];
                    en_clr[0] = mr_r[0][1:0] == gpt_pkg::MODE_ONESHOT;
                end else begin
                    c32_nxt = c32 - 32'h0000_0001;
                end
            end
            if (mrtc && run[0] && tick) begin
                c32_nxt = (c32 == mt32) ? 32'h0000_0000 : c32 + 32'h0000_0001;
                ev_set[gpt_pkg::ST_RTC] = c32 == mt32;
            end
            // Load write overrides counting
            if (wr_at(gpt_pkg::OFF_ALOAD)) begin
                c32_nxt = hwdata_in;
            end
            {cnt_nxt[1], cnt_nxt[0]} = c32_nxt;
        end else if (m16) begin
            // Each narrow timer follows its own mode
            for (int n = 0; n < 2; n++) begin
                if (is_timer(mr_r[n]) && run[n]) begin
                    if (pre_r[n] != 8'h00) begin
                        pre_nxt[n] = pre_r[n] - 8'h01;
                    end else begin
                        pre_nxt[n] = psr_r[n];
                        if (cnt_r[n] == 16'h0000) begin
                            cnt_nxt[n] = ilr_r[n];
                            ev_set[n*gpt_pkg::B_SHIFT+gpt_pkg::ST_TO] = 1'b1;
                            trig_nxt = trig_nxt || ote[n];
                            en_clr[n] = mr_r[n][1:0] == gpt_pkg::MODE_ONESHOT;
                        end else begin
                            cnt_nxt[n] = cnt_dec[n];
                        end
                    end
                end else if (mr_r[n][1:0] == gpt_pkg::MODE_EDGE && !mr_r[n][gpt_pkg::MR_CAP]
                        && run[n] && hit[n]) begin
                    // No prescaler; stops at match
                    if (cnt_dec[n] == mat_r[n]) begin
                        cnt_nxt[n] = ilr_r[n];
                        ev_set[n*gpt_pkg::B_SHIFT+gpt_pkg::ST_CM] = 1'b1;
                        en_clr[n] = 1'b1;
                    end else begin
                        cnt_nxt[n] = cnt_dec[n];
                    end
                end
                // Load write restarts count and prescaler
                if (wr_at(n == 0 ? gpt_pkg::OFF_ALOAD : gpt_pkg::OFF_BLOAD)) begin
                    cnt_nxt[n] = hwdata_in[15:0];
                    pre_nxt[n] = psr_r[n];
                end
            end
        end
        // First clock selection wins over all
        if (rtc_first) begin
            {cnt_nxt[1], cnt_nxt[0]} = gpt_pkg::RTC_PRELOAD;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_r <= gpt_pkg::CFG_32;
            mr_r <= '{3'h0, 3'h0};
            ctl_r <= 16'h0000;
            imr_r <= 16'h0000;
            ris_r <= 16'h0000;
            ilr_r <= '{gpt_pkg::CNT_RST, gpt_pkg::CNT_RST};
            mat_r <= '{gpt_pkg::CNT_RST, gpt_pkg::CNT_RST};
            cnt_r <= '{gpt_pkg::CNT_RST, gpt_pkg::CNT_RST};
            psr_r <= '{gpt_pkg::PRE_RST, gpt_pkg::PRE_RST};
            pre_r <= '{gpt_pkg::PRE_RST, gpt_pkg::PRE_RST};
            rtc_done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
            ris_r <= (ris_r & ~icr_clr) | ev_set;
            ctl_r <= wr_at(gpt_pkg::OFF_CTL) ? hwdata_in[15:0] : (ctl_r & ~en_mask);
            rtc_done_r <= rtc_done_r || rtc_first;
            // Plain register writes
            if (wr_at(gpt_pkg::OFF_CFG)) cfg_r <= hwdata_in[2:0];
            if (wr_at(gpt_pkg::OFF_AMODE)) mr_r[0] <= hwdata_in[2:0];
            if (wr_at(gpt_pkg::OFF_BMODE)) mr_r[1] <= hwdata_in[2:0];
            if (wr_at(gpt_pkg::OFF_IMR)) imr_r <= hwdata_in[15:0];
            if (wr_at(gpt_pkg::OFF_APRE)) psr_r[0] <= hwdata_in[7:0];
            if (wr_at(gpt_pkg::OFF_BPRE)) psr_r[1] <= hwdata_in[7:0];
            // Wide writes fill both halves
            if (wr_at(gpt_pkg::OFF_ALOAD)) begin
                ilr_r[0] <= hwdata_in[15:0];
                if (wide) ilr_r[1] <= hwdata_in[31:16];
            end
            if (wr_at(gpt_pkg::OFF_BLOAD)) ilr_r[1] <= hwdata_in[15:0];
            if (wr_at(gpt_pkg::OFF_AMATCH)) begin
                mat_r[0] <= hwdata_in[15:0];
                if (wide) mat_r[1] <= hwdata_in[31:16];
            end
            if (wr_at(gpt_pkg::OFF_BMATCH)) mat_r[1] <= hwdata_in[15:0];
        end
    end

    // Interrupt and trigger outputs
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            irq_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            irq_r <= |(ris_r & imr_r);
            trig_r <= trig_nxt;
        end
    end
    assign irq_out = irq_r;
    assign adc_trig_out = trig_r;

    // Read selection
    always_comb begin
        case (addr_r)
            gpt_pkg::OFF_CFG: rd_data = 32'(cfg_r);
            gpt_pkg::OFF_AMODE: rd_data = 32'(mr_r[0]);
            gpt_pkg::OFF_BMODE: rd_data = 32'(mr_r[1]);
            gpt_pkg::OFF_CTL: rd_data = 32'(ctl_r);
            gpt_pkg::OFF_IMR: rd_data = 32'(imr_r);
            gpt_pkg::OFF_RIS: rd_data = 32'(ris_r);
            gpt_pkg::OFF_MIS: rd_data = 32'(ris_r & imr_r);
            gpt_pkg::OFF_ALOAD: rd_data = wide ? l32 : 32'(ilr_r[0]);
            gpt_pkg::OFF_BLOAD: rd_data = 32'(ilr_r[1]);
            gpt_pkg::OFF_AMATCH: rd_data = wide ? mt32 : 32'(mat_r[0]);
            gpt_pkg::OFF_BMATCH: rd_data = 32'(mat_r[1]);
            gpt_pkg::OFF_APRE: rd_data = 32'(psr_r[0]);
            gpt_pkg::OFF_BPRE: rd_data = 32'(psr_r[1]);
            gpt_pkg::OFF_AVAL: rd_data = wide ? c32 : 32'(cnt_r[0]);
            gpt_pkg::OFF_BVAL: rd_data = 32'(cnt_r[1]);
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire to32 = m32 && run[0] && c32 == 32'h0000_0000;
    wire lda = wr_at(gpt_pkg::OFF_ALOAD);
    wire ctlw = wr_at(gpt_pkg::OFF_CTL);

    // Wide time-out
    a_wide_flag: assert property (to32 |=> ris_r[gpt_pkg::ST_TO])
        else $error("wide time-out flag not set");

    a_oneshot_stop: assert property (to32 && mr_r[0][1:0] == gpt_pkg::MODE_ONESHOT && !ctlw
        |=> !ctl_r[gpt_pkg::CTL_EN])
        else $error("one-shot did not stop");

    a_wide_reload: assert property (to32 && !lda && !rtc_first |=> c32 == $past(l32))
        else $error("wide reload wrong");

    // Load and freeze
    a_load_next: assert property (lda && m32 |=> c32 == $past(hwdata_in))
        else $error("load write not applied");

    a_debug_freeze: assert property (m32 && en[0] && stall[0] && debug_halt_in && !lda
        && !rtc_first |=> $stable(c32))
        else $error("counter moved during halt");

    // Clock mode
    a_rtc_roll: assert property (mrtc && run[0] && tick && c32 == mt32 && !lda && !rtc_first
        |=> c32 == 32'h0000_0000 && ris_r[gpt_pkg::ST_RTC])
        else $error("clock match rollover wrong");

    a_rtc_preload: assert property (rtc_first |=> c32 == gpt_pkg::RTC_PRELOAD ##1 rtc_done_r)
        else $error("clock preload wrong");

    // Narrow timers
    a_prescale_hold: assert property (m16 && is_timer(mr_r[0]) && run[0] && pre_r[0] != 8'h00
        && !lda |=> $stable(cnt_r[0]))
        else $error("count moved inside prescale");

    a_edge_stop: assert property (m16 && mr_r[0] == 3'(gpt_pkg::MODE_EDGE) && run[0] && hit[0]
        && cnt_dec[0] == mat_r[0] && !lda && !ctlw
        |=> !en[0] && cnt_r[0] == $past(ilr_r[0]) && ris_r[gpt_pkg::ST_CM])
        else $error("edge match handling wrong");

    // Outputs and bus
    a_trig_gate: assert property (to32 && !ote[0] |=> !adc_trig_out)
        else $error("trigger without enable");

    a_irq_mask: assert property (ris_r[gpt_pkg::ST_TO] && imr_r[gpt_pkg::ST_TO] |=> irq_out)
        else $error("masked flag without interrupt");

    a_read_wait: assert property (addr_ok && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");


    // Main scenarios reached
    c_oneshot: cover property (to32 && mr_r[0][1:0] == gpt_pkg::MODE_ONESHOT);
    c_rtc_match: cover property (mrtc && tick && c32 == mt32);
    c_edge_match: cover property (ev_set[gpt_pkg::ST_CM]);
    c_prescaled: cover property (m16 && ev_set[gpt_pkg::ST_TO] && psr_r[0] != 8'h00);
    c_wide_freeze: cover property (m32 && en[0] && stall[0] && debug_halt_in);
endmodule : gpt_timer_unit

// ---- pkg/gpt_pkg.sv ----
/*
 * Constants for the dual 16-bit timer unit: register offsets, field
 * positions, mode codes and reset values.
 * Assumes a 32-bit AHB-Lite slave port and word-aligned registers.
 */
// Notes on behaviour
// - Config 0 is 32-bit timer, 1 is clock
// - Wide load and value words are B:A
// - Wide timer uses only timer A mode field
// - Wide count down, reload after zero, one-shot stops
// - Wide zero sets sticky time-out flag, masked copy
// - Time-out trigger pulse only when trigger enabled
// - Load write reaches the counter next cycle
// - Freeze bit stops counter during debug halt
// - Clock counts up, first selection preloads one
// - Source gives 32768 Hz, divided to 1 Hz
// - Clock match rolls count to zero, continues
// - Clock match sets flag, clear bit clears it
// - Clock run bit overrides freeze during halt
// - Config 4 splits unit into two timers
// - Narrow timer has optional 8-bit prescaler
// - Narrow count down, reload after zero, one-shot stops
// - Narrow zero sets sticky time-out flag per timer
// - Prescale p gives one step per p+1 clocks
// - Edge mode counts selected edges, no prescaler
// - Edge match sets flag, reloads, stops timer
// - Reset gives counters and loads FFFF, prescale 0
// - Mode field 1 one-shot, 2 periodic
// - Mode field 3, capture clear, edge count
package gpt_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_AMODE = 8'h04;
    localparam logic [7:0] OFF_BMODE = 8'h08;
    localparam logic [7:0] OFF_CTL = 8'h0C;
    localparam logic [7:0] OFF_IMR = 8'h18;
    localparam logic [7:0] OFF_RIS = 8'h1C;
    localparam logic [7:0] OFF_MIS = 8'h20;
    localparam logic [7:0] OFF_ICR = 8'h24;
    localparam logic [7:0] OFF_ALOAD = 8'h28;
    localparam logic [7:0] OFF_BLOAD = 8'h2C;
    localparam logic [7:0] OFF_AMATCH = 8'h30;
    localparam logic [7:0] OFF_BMATCH = 8'h34;
    localparam logic [7:0] OFF_APRE = 8'h38;
    localparam logic [7:0] OFF_BPRE = 8'h3C;
    localparam logic [7:0] OFF_AVAL = 8'h48;
    localparam logic [7:0] OFF_BVAL = 8'h4C;
    // ------------------------------------------------------------
    // Modes and fields
    // ------------------------------------------------------------
    localparam logic [2:0] CFG_32 = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam logic [2:0] CFG_16 = 3'h4;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_EDGE = 2'h3;
    localparam int MR_CAP = 2;
    localparam int CTL_EN = 0;
    localparam int CTL_STALL = 1;
    localparam int CTL_EVT = 2;
    localparam int CTL_CLOCK_RUN_ENABLE = 4;
    localparam int CTL_OTE = 5;
    localparam int B_SHIFT = 8;
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_BOTH = 2'h3;
    localparam int ST_TO = 0;
    localparam int ST_CM = 1;
    localparam int ST_RTC = 3;
    // ------------------------------------------------------------
    // Reset values and rates
    // ------------------------------------------------------------
    localparam logic [15:0] CNT_RST = 16'hFFFF;
    localparam logic [7:0] PRE_RST = 8'h00;
    localparam logic [31:0] RTC_PRELOAD = 32'h0000_0001;
    localparam int RTC_IN_HZ = 32768;
    localparam int RTC_OUT_HZ = 1;
    localparam int RTC_DIV = RTC_IN_HZ / RTC_OUT_HZ;
endpackage : gpt_pkg

// ---- test/gpt_pin_source.sv ----
/*
 * Pin source that stands in for the outside world on one capture pin:
 * event pulses for edge counting, or the slow clock for clock mode.
 * Assumes the caller gives a pulse count and a phase width in clocks.
 */
`timescale 1ns/100ps
module gpt_pin_source (
    input wire logic clk_sys_in,
    output logic pin_out
);
    // ------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------
    // Pin rests low between bursts, so no stray edge reaches the unit
    initial begin
        pin_out = 1'h0;
    end

    // Emits n pulses, each phase held w clocks and never under two
    task automatic pulses(input int n, input int w);
        int hw = (w < 2) ? 2 : w;
        repeat (n) begin
            @(posedge clk_sys_in);
            pin_out <= 1'h1;
            repeat (hw) @(posedge clk_sys_in);
            pin_out <= 1'h0;
            repeat (hw - 1) @(posedge clk_sys_in);
        end
    endtask : pulses
endmodule : gpt_pin_source

// ---- test/general_purpose_timer_modes_bench.sv ----
/*
 * Self-checking bench for the dual timer unit. Reads queue their
 * expected word; a monitor compares it when the read data returns.
 * Assumes the unit is the only AHB-Lite slave and two pin sources.
 */
`timescale 1ns/100ps
module general_purpose_timer_modes_bench;
    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    logic clk_sys_in, rst_in, hsel, hwrite, debug_halt, rd_phase;
    logic hready, hresp, irq, adc_trig, ccp_even, ccp_odd;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [31:0] exp_q[$];
    int mismatches, num_checks, trig_cnt, cycles, w, seed;
    time t0;

    gpt_timer_unit #(.RTC_DIV(4)) DUT (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .ccp_even_in(ccp_even), .ccp_odd_in(ccp_odd),
        .debug_halt_in(debug_halt), .irq_out(irq), .adc_trig_out(adc_trig));
    gpt_pin_source SRC_A (.clk_sys_in(clk_sys_in), .pin_out(ccp_even));
    gpt_pin_source SRC_B (.clk_sys_in(clk_sys_in), .pin_out(ccp_odd));

    // ------------------------------------------------------------
    // Clock, monitor and helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys_in = 1'h0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    // Read data check, trigger pulse count and hang guard
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (adc_trig === 1'h1) trig_cnt <= trig_cnt + 1;
        if (rd_phase === 1'h1 && hready === 1'h1) begin
            check(hrdata, exp_q.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
        if (cycles > 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, expv);
        end
    endtask : check

    // One single transfer; holds each phase until ready is sampled high
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        hsel <= 1'h1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr_en;
        do @(posedge clk_sys_in); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= ~wr_en;
        do @(posedge clk_sys_in); while (hready !== 1'h1);
        rd_phase <= 1'h0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'h0, a, 32'h0000_0000);
    endtask : rd

    task automatic wait_trig(input int lim);
        int k = 0;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (adc_trig !== 1'h1 && k < lim);
    endtask : wait_trig

    task automatic do_reset();
        rst_in <= 1'h1;
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        @(posedge clk_sys_in);
    endtask : do_reset

    task automatic stop_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h9864;
        {hsel, hwrite, rd_phase, debug_halt, rst_in} = 5'h01;
        {haddr, hwdata, htrans} = 66'h0;
        do_reset();
        // Reset state, unmapped word, wide load and value words
        rd(gpt_pkg::OFF_ALOAD, 32'hFFFF_FFFF);
        rd(gpt_pkg::OFF_AVAL, 32'hFFFF_FFFF);
        rd(gpt_pkg::OFF_APRE, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        rv = $random(seed);
        wr(gpt_pkg::OFF_ALOAD, rv);
        rd(gpt_pkg::OFF_ALOAD, rv);
        rd(gpt_pkg::OFF_BLOAD, {16'h0000, rv[31:16]});
        rd(gpt_pkg::OFF_AVAL, rv);
        // Wide one-shot with trigger and unmasked time-out
        wr(gpt_pkg::OFF_AMODE, {30'h0, gpt_pkg::MODE_ONESHOT});
        wr(gpt_pkg::OFF_BMODE, {30'h0, gpt_pkg::MODE_PERIODIC});
        wr(gpt_pkg::OFF_ALOAD, 32'h0000_0020);
        wr(gpt_pkg::OFF_IMR, 32'h0000_0001);
        wr(gpt_pkg::OFF_CTL, 32'h0000_0021);
        wait_trig(100);
        repeat (60) @(posedge clk_sys_in);
        check(trig_cnt, 1);
        rd(gpt_pkg::OFF_CTL, 32'h0000_0020);
        rd(gpt_pkg::OFF_AVAL, 32'h0000_0020);
        rd(gpt_pkg::OFF_MIS, 32'h0000_0001);
        check({31'h0, irq}, 1);
        wr(gpt_pkg::OFF_ICR, 32'h0000_0001);
        rd(gpt_pkg::OFF_RIS, 32'h0000_0000);
        // Wide periodic, trigger off
        wr(gpt_pkg::OFF_AMODE, {30'h0, gpt_pkg::MODE_PERIODIC});
        wr(gpt_pkg::OFF_CTL, 32'h0000_0001);
        repeat (80) @(posedge clk_sys_in);
        rd(gpt_pkg::OFF_CTL, 32'h0000_0001);
        check(trig_cnt, 1);
        rd(gpt_pkg::OFF_RIS, 32'h0000_0001);
        // Wide periodic frozen by debug halt
        debug_halt <= 1'h1;
        wr(gpt_pkg::OFF_CTL, 32'h0000_0003);
        wr(gpt_pkg::OFF_ALOAD, 32'h0000_0040);
        repeat (20) @(posedge clk_sys_in);
        rd(gpt_pkg::OFF_AVAL, 32'h0000_0040);
        // Narrow periodic, prescale 3 and load 9, masked off
        wr(gpt_pkg::OFF_ICR, 32'h0000_030B);
        wr(gpt_pkg::OFF_CFG, {29'h0, gpt_pkg::CFG_16});
        wr(gpt_pkg::OFF_IMR, 32'h0000_0000);
        wr(gpt_pkg::OFF_APRE, 32'h0000_0003);
        wr(gpt_pkg::OFF_ALOAD, 32'h0000_0009);
        wr(gpt_pkg::OFF_CTL, 32'h0000_0021);
        wait_trig(200);
        t0 = $time;
        wait_trig(200);
        check(32'(($time - t0) / 40), 40);
        rd(gpt_pkg::OFF_RIS, 32'h0000_0001);
        check({31'h0, irq}, 0);
        // Timer B frozen by debug halt
        debug_halt <= 1'h1;
        wr(gpt_pkg::OFF_BLOAD, 32'h0000_1234);
        wr(gpt_pkg::OFF_CTL, 32'h0000_0300);
        repeat (20) @(posedge clk_sys_in);
        rd(gpt_pkg::OFF_BVAL, 32'h0000_1234);
        // Edge count: A both edges 10 to 6, B falling 5 to 2
        wr(gpt_pkg::OFF_ICR, 32'h0000_030B);
        wr(gpt_pkg::OFF_AMODE, {30'h0, gpt_pkg::MODE_EDGE});
        wr(gpt_pkg::OFF_BMODE, {30'h0, gpt_pkg::MODE_EDGE});
        wr(gpt_pkg::OFF_ALOAD, 32'h0000_000A);
        wr(gpt_pkg::OFF_AMATCH, 32'h0000_0006);
        wr(gpt_pkg::OFF_BLOAD, 32'h0000_0005);
        wr(gpt_pkg::OFF_BMATCH, 32'h0000_0002);
        wr(gpt_pkg::OFF_IMR, 32'h0000_0202);
        wr(gpt_pkg::OFF_CTL, 32'h0000_050D);
        w = 2 + ($random(seed) & 3);
        fork
            SRC_A.pulses(6, w);
            SRC_B.pulses(6, w);
        join
        repeat (8) @(posedge clk_sys_in);
        rd(gpt_pkg::OFF_RIS, 32'h0000_0202);
        rd(gpt_pkg::OFF_CTL, 32'h0000_040C);
        rd(gpt_pkg::OFF_AVAL, 32'h0000_000A);
        rd(gpt_pkg::OFF_BVAL, 32'h0000_0005);
        check({31'h0, irq}, 1);
        // Clock mode, divider 4, match 2, runs through halt
        do_reset();
        wr(gpt_pkg::OFF_CFG, {29'h0, gpt_pkg::CFG_RTC});
        wr(gpt_pkg::OFF_AMATCH, 32'h0000_0002);
        wr(gpt_pkg::OFF_IMR, 32'h0000_0008);
        wr(gpt_pkg::OFF_CTL, 32'h0000_0013);
        rd(gpt_pkg::OFF_AVAL, 32'h0000_0001);
        SRC_A.pulses(4, w);
        repeat (8) @(posedge clk_sys_in);
        rd(gpt_pkg::OFF_AVAL, 32'h0000_0002);
        SRC_A.pulses(4, w);
        repeat (8) @(posedge clk_sys_in);
        rd(gpt_pkg::OFF_AVAL, 32'h0000_0000);
        rd(gpt_pkg::OFF_MIS, 32'h0000_0008);
        wr(gpt_pkg::OFF_ICR, 32'h0000_0008);
        rd(gpt_pkg::OFF_RIS, 32'h0000_0000);
        stop_test();
    end
endmodule : general_purpose_timer_modes_bench
